// [aos_map.vh]
// register offsets, field positions, reset values and state codes
`ifndef AOS_MAP_VH
`define AOS_MAP_VH
`define AOS_OFF_CTRL      8'h00
`define AOS_OFF_HIFEED    8'h04
`define AOS_OFF_LOFEED    8'h08
`define AOS_OFF_OFFSET    8'h0C
`define AOS_OFF_STATUS    8'h10
`define AOS_OFF_IRQ_STAT  8'h14
`define AOS_OFF_IRQ_MASK  8'h18
`define AOS_CTRL_START    0
`define AOS_CTRL_METH_LO  1
`define AOS_CTRL_METH_HI  2
`define AOS_CTRL_DIR      3
`define AOS_CTRL_DECEL    4
`define AOS_CTRL_PROXNC   5
`define AOS_CTRL_PROXFIT  6
`define AOS_CTRL_ABSENC   7
`define AOS_CTRL_RST      8'h40
`define AOS_FEED_RST      16'h0000
`define AOS_OFFSET_RST    32'h0000_0000
`define AOS_METH_PWRON    2'b00
`define AOS_METH_REVERSE  2'b01
`define AOS_METH_ONEDIR   2'b10
`define AOS_ST_DONE       0
`define AOS_ST_ERR        1
`define AOS_ST_BUSY       2
`define AOS_ST_FIXED      3
`define AOS_IRQ_DONE      0
`define AOS_IRQ_ERR       1
`define AOS_IRQ_REV       2
`define AOS_S_IDLE        4'h0
`define AOS_S_FAST        4'h1
`define AOS_S_SLOW        4'h2
`define AOS_S_WAITZ       4'h3
`define AOS_S_REVERSE     4'h4
`define AOS_S_ZERO        4'h5
`define AOS_S_PTP         4'h6
`define AOS_S_DONE        4'h7
`define AOS_S_ERROR       4'h8
`endif

// [aos_edge.v]
// per-bit rising and falling edge detector
`timescale 1ns/100ps
module aos_edge #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] sig,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // one flop per bit, so each bit has a single driver
      reg prev_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_q <= 1'b0;
        end else begin
          prev_q <= sig[i];
        end
      end
      assign rise[i] = sig[i] & ~prev_q;
      assign fall[i] = ~sig[i] & prev_q;
    end
  endgenerate
endmodule // aos_edge

// [aos_axis_origin_search.v]
// origin search engine for one servo axis with an ahb-lite register slave
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`include "aos_map.vh"
module aos_axis_origin_search (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output wire        irq,
  input  wire        cw_limit_n,
  input  wire        ccw_limit_n,
  input  wire        prox_in,
  input  wire        index_in,
  output reg         drive_en,
  output reg         drive_ccw,
  output reg  [15:0] feed_rate,
  output reg         counter_pulse,
  output reg         ctrl_zero,
  output reg         origin_fixed,
  output reg         ptp_start,
  output reg  [31:0] ptp_offset,
  input  wire        ptp_done,
  output reg         ref_fixed,
  output wire        decel_sel
);
  // bus slave
  reg        wr_pend_q;
  reg [7:0]  wr_addr_q;
  reg [7:0]  ctrl_q;
  reg [15:0] hifeed_q;
  reg [15:0] lofeed_q;
  reg [31:0] offset_q;
  reg [2:0]  irq_stat_q;
  reg [2:0]  irq_mask_q;
  reg        done_q;
  reg        err_q;
  reg        fixed_q;
  reg [3:0]  state_q;
  reg [3:0]  state_d;
  reg        dir_q;
  reg        pwr_pend_q;
  wire       acc;
  wire       wr_now;
  wire       start_req;
  wire [1:0] method;
  wire [1:0] start_meth;
  wire       dir_d;
  wire       busy;
  reg  [31:0] rd_mux;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel & hready & htrans[1];
  assign wr_now    = wr_pend_q;
  assign method    = ctrl_q[`AOS_CTRL_METH_HI:`AOS_CTRL_METH_LO];
  // method written with the start bit is not stored yet at that edge
  assign start_meth = hwdata[`AOS_CTRL_METH_HI:`AOS_CTRL_METH_LO];
  assign decel_sel = ctrl_q[`AOS_CTRL_DECEL];
  assign busy      = (state_q != `AOS_S_IDLE);
  assign start_req = wr_now && (wr_addr_q == `AOS_OFF_CTRL) &&
                     hwdata[`AOS_CTRL_START];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc & hwrite;
      if (acc) begin
        wr_addr_q <= haddr;
      end
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      `AOS_OFF_CTRL:     rd_mux = {24'h00_0000, ctrl_q};
      `AOS_OFF_HIFEED:   rd_mux = {16'h0000, hifeed_q};
      `AOS_OFF_LOFEED:   rd_mux = {16'h0000, lofeed_q};
      `AOS_OFF_OFFSET:   rd_mux = offset_q;
      `AOS_OFF_STATUS:   rd_mux = {28'h000_0000, fixed_q, busy,
                                   err_q, done_q};
      `AOS_OFF_IRQ_STAT: rd_mux = {29'h000_0000, irq_stat_q};
      `AOS_OFF_IRQ_MASK: rd_mux = {29'h000_0000, irq_mask_q};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // configuration; start bit is not stored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q     <= `AOS_CTRL_RST;
      hifeed_q   <= `AOS_FEED_RST;
      lofeed_q   <= `AOS_FEED_RST;
      offset_q   <= `AOS_OFFSET_RST;
      irq_mask_q <= 3'h0;
    end else if (wr_now) begin
      case (wr_addr_q)
        `AOS_OFF_CTRL:     ctrl_q <= {hwdata[7:1], 1'b0};
        `AOS_OFF_HIFEED:   hifeed_q <= hwdata[15:0];
        `AOS_OFF_LOFEED:   lofeed_q <= hwdata[15:0];
        `AOS_OFF_OFFSET:   offset_q <= hwdata;
        `AOS_OFF_IRQ_MASK: irq_mask_q <= hwdata[2:0];
        default:           irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // sensor conditioning
  wire prox_act;
  wire cw_hit;
  wire ccw_hit;
  wire lim_ahead;
  wire lim_behind;
  wire ref_act;
  wire [1:0] ev_rise;
  wire [1:0] ev_fall;
  wire index_rise;
  wire ref_fall;

  assign prox_act   = prox_in ^ ctrl_q[`AOS_CTRL_PROXNC];
  assign cw_hit     = ~cw_limit_n;
  assign ccw_hit    = ~ccw_limit_n;
  assign lim_ahead  = dir_q ? ccw_hit : cw_hit;
  assign lim_behind = dir_q ? cw_hit : ccw_hit;
  assign ref_act    = ctrl_q[`AOS_CTRL_PROXFIT] ? prox_act :
                      lim_behind;

  aos_edge #(
    .WIDTH (2)
  ) u_edge (
    .clk   (hclk),
    .rst_n (hresetn),
    .sig   ({ref_act, index_in}),
    .rise  (ev_rise),
    .fall  (ev_fall)
  );

  assign index_rise = ev_rise[0];
  assign ref_fall   = ev_fall[1];

  // search sequencer
  wire use_offset;
  assign use_offset = ~ctrl_q[`AOS_CTRL_ABSENC] &&
                      (offset_q != 32'h0000_0000);

  always @* begin
    state_d = state_q;
    case (state_q)
      `AOS_S_IDLE: begin
        if (start_req) begin
          if (start_meth == `AOS_METH_PWRON) begin
            state_d = `AOS_S_DONE;
          end else if (start_meth == `AOS_METH_REVERSE ||
                       start_meth == `AOS_METH_ONEDIR) begin
            state_d = `AOS_S_FAST;
          end else begin
            state_d = `AOS_S_ERROR;
          end
        end
      end
      `AOS_S_FAST: begin
        if (lim_ahead) begin
          if (method == `AOS_METH_REVERSE) begin
            state_d = `AOS_S_REVERSE;
          end else begin
            state_d = `AOS_S_ERROR;
          end
        end else if (ref_act) begin
          state_d = `AOS_S_SLOW;
        end
      end
      `AOS_S_SLOW: begin
        if (lim_ahead) begin
          if (method == `AOS_METH_REVERSE) begin
            state_d = `AOS_S_REVERSE;
          end else begin
            state_d = `AOS_S_ERROR;
          end
        end else if (ref_fall) begin
          state_d = `AOS_S_WAITZ;
        end
      end
      `AOS_S_WAITZ: begin
        if (index_rise) begin
          state_d = `AOS_S_ZERO;
        end else if (lim_ahead) begin
          if (method == `AOS_METH_REVERSE) begin
            state_d = `AOS_S_REVERSE;
          end else begin
            state_d = `AOS_S_ERROR;
          end
        end
      end
      `AOS_S_REVERSE: begin
        state_d = `AOS_S_FAST;
      end
      `AOS_S_ZERO: begin
        state_d = use_offset ? `AOS_S_PTP : `AOS_S_DONE;
      end
      `AOS_S_PTP: begin
        if (ptp_done) begin
          state_d = `AOS_S_DONE;
        end
      end
      `AOS_S_DONE: begin
        state_d = `AOS_S_IDLE;
      end
      `AOS_S_ERROR: begin
        state_d = `AOS_S_IDLE;
      end
      default: begin
        state_d = `AOS_S_IDLE;
      end
    endcase
  end

  // drive pin takes the new direction in the same cycle as the state
  assign dir_d = (state_q == `AOS_S_IDLE && start_req) ?
                 hwdata[`AOS_CTRL_DIR] :
                 ((state_q == `AOS_S_REVERSE) ? ~dir_q : dir_q);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= `AOS_S_IDLE;
      dir_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      dir_q   <= dir_d;
    end
  end

  // drive outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_en      <= 1'b0;
      drive_ccw     <= 1'b0;
      feed_rate     <= 16'h0000;
      counter_pulse <= 1'b0;
      ctrl_zero     <= 1'b0;
      ptp_start     <= 1'b0;
      ptp_offset    <= 32'h0000_0000;
    end else begin
      drive_ccw     <= dir_d;
      counter_pulse <= (state_d == `AOS_S_REVERSE);
      ctrl_zero     <= (state_d == `AOS_S_ZERO);
      ptp_start     <= (state_q == `AOS_S_ZERO) && use_offset;
      case (state_d)
        `AOS_S_FAST: begin
          drive_en  <= 1'b1;
          feed_rate <= hifeed_q;
        end
        `AOS_S_SLOW, `AOS_S_WAITZ: begin
          drive_en  <= 1'b1;
          feed_rate <= lofeed_q;
        end
        default: begin
          drive_en  <= 1'b0;
          feed_rate <= 16'h0000;
        end
      endcase
      if (state_q == `AOS_S_ZERO && use_offset) begin
        ptp_offset <= offset_q;
      end
    end
  end

  // origin events and status
  wire ev_done;
  wire ev_err;
  wire ev_rev;
  assign ev_done = (state_q == `AOS_S_DONE);
  assign ev_err  = (state_q == `AOS_S_ERROR);
  assign ev_rev  = (state_q == `AOS_S_REVERSE);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      origin_fixed <= 1'b0;
      ref_fixed    <= 1'b0;
      pwr_pend_q   <= 1'b1;
      done_q       <= 1'b0;
      err_q        <= 1'b0;
      fixed_q      <= 1'b0;
    end else begin
      pwr_pend_q   <= 1'b0;
      origin_fixed <= (state_d == `AOS_S_ZERO) ||
                      (pwr_pend_q && method == `AOS_METH_PWRON) ||
                      (ev_done && method == `AOS_METH_PWRON);
      ref_fixed    <= ev_done;
      if (pwr_pend_q && method == `AOS_METH_PWRON) begin
        done_q  <= 1'b1;
        fixed_q <= 1'b1;
      end else if (state_q == `AOS_S_IDLE && start_req) begin
        done_q  <= 1'b0;
        err_q   <= 1'b0;
        fixed_q <= 1'b0;
      end else if (ev_done) begin
        done_q  <= 1'b1;
        fixed_q <= 1'b1;
      end else if (ev_err) begin
        err_q <= 1'b1;
      end
    end
  end

  // sticky interrupt status, set wins over write-one-to-clear
  wire [2:0] irq_set;
  wire [2:0] irq_clr;
  assign irq_set = {ev_rev, ev_err, ev_done};
  assign irq_clr = (wr_now && wr_addr_q == `AOS_OFF_IRQ_STAT) ?
                   hwdata[2:0] : 3'h0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  wire unused_ok;
  assign unused_ok = &{1'b0, hsize, htrans[0]};
endmodule // aos_axis_origin_search

// [aos_chk_sva.sv]
// concurrent checks on the origin search block outputs
`timescale 1ns/100ps
module aos_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hreadyout,
  input wire        hresp,
  input wire        index_in,
  input wire        drive_en,
  input wire        drive_ccw,
  input wire [15:0] feed_rate,
  input wire        counter_pulse,
  input wire        ctrl_zero,
  input wire        origin_fixed,
  input wire        ptp_start,
  input wire        ref_fixed
);
  reg dir_q;
  // direction of the last travel, frozen while stopped
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) dir_q <= 1'b0;
    else if (drive_en) dir_q <= drive_ccw;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  rev_stop_a: assert property (counter_pulse |-> !drive_en)
    else $error("counter pulse while driving");
  pulse_one_a: assert property (counter_pulse |=> !counter_pulse)
    else $error("counter pulse longer than one cycle");
  rev_dir_a: assert property (counter_pulse |->
    ##[1:4] ($rose(drive_en) && drive_ccw != dir_q))
    else $error("no restart in the opposite direction");
  zero_origin_a: assert property (ctrl_zero |-> origin_fixed && !drive_en)
    else $error("control zero without origin fix");
  zero_index_a: assert property (ctrl_zero |->
    $past(index_in) || $past(index_in, 2))
    else $error("origin fixed without index pulse");
  ptp_after_a: assert property (ptp_start |-> $past(ctrl_zero))
    else $error("offset move not right after control zero");
  idle_feed_a: assert property (!drive_en |-> feed_rate == 16'h0000)
    else $error("feed rate while not driving");
  fixed_still_a: assert property (origin_fixed |-> !drive_en)
    else $error("origin fixed while moving");
  ref_end_a: assert property (ref_fixed |-> !drive_en ##1 !ref_fixed)
    else $error("reference fix malformed");
  rev_c: cover property (counter_pulse);
  ptp_c: cover property (ptp_start);
  ref_c: cover property (ref_fixed);
endmodule // aos_chk

bind aos_axis_origin_search aos_chk i_chk (.hclk, .hresetn, .hreadyout, .hresp,
  .index_in, .drive_en, .drive_ccw, .feed_rate, .counter_pulse, .ctrl_zero,
  .origin_fixed, .ptp_start, .ref_fixed);

// [aos_axis_model.sv]
// axis model: position, limit and proximity switches, index, offset mover
`timescale 1ns/100ps
module aos_axis_model (
  input  wire       hclk,
  input  wire       place,
  input  wire       nc,
  input  wire       drive_en,
  input  wire       drive_ccw,
  input  wire       ptp_start,
  input  wire [4:0] dly,
  output wire       cw_limit_n,
  output wire       ccw_limit_n,
  output wire       prox_in,
  output wire       index_in,
  output reg        ptp_done
);
  integer pos;
  integer div;
  integer cnt;
  // contacts open at the limit
  assign cw_limit_n  = !(pos >= 40);
  assign ccw_limit_n = !(pos <= -60);
  assign prox_in     = (pos <= -10 && pos >= -20) ^ nc;
  assign index_in    = (pos % 16) == 0;
  initial begin
    pos = 0;
    div = 0;
    cnt = 0;
    ptp_done = 1'b0;
  end
  always @(posedge hclk) begin
    div <= div + 1;
    ptp_done <= (cnt == 1);
    if (place) pos <= 0;
    else if (drive_en && div % 4 == 3) pos <= drive_ccw ? pos - 1 : pos + 1;
    if (ptp_start) cnt <= dly + 1;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule // aos_axis_model

// [tb_axis_origin_search.sv]
// self-checking bench for the axis origin search block
`timescale 1ns/100ps
`include "aos_map.vh"
module tb_axis_origin_search;
  reg         hclk, hresetn, hsel, hwrite, place, nc, de_q;
  reg  [7:0]  haddr;
  reg  [1:0]  htrans;
  reg  [4:0]  dly;
  reg  [31:0] hwdata, v, off, hi, lo, st;
  reg  [15:0] rise_feed, last_feed;
  wire [31:0] hrdata, ptp_offset;
  wire [15:0] feed_rate;
  wire        hreadyout, hresp, irq, cw_limit_n, ccw_limit_n, prox_in;
  wire        index_in, drive_en, drive_ccw, counter_pulse, ctrl_zero;
  wire        origin_fixed, ptp_start, ptp_done, ref_fixed, decel_sel;
  integer     mismatches, n_compared, cycles, n_rev, n_ptp, n_move, k;
  aos_axis_origin_search i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .irq, .cw_limit_n, .ccw_limit_n, .prox_in, .index_in, .drive_en,
    .drive_ccw, .feed_rate, .counter_pulse, .ctrl_zero, .origin_fixed,
    .ptp_start, .ptp_offset, .ptp_done, .ref_fixed, .decel_sel);
  aos_axis_model i_model (.hclk, .place, .nc, .drive_en, .drive_ccw,
    .ptp_start, .dly, .cw_limit_n, .ccw_limit_n, .prox_in, .index_in,
    .ptp_done);
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  function [31:0] exp_status(input done, input err, input fixed);
    begin
      exp_status = 32'h0000_0000;
      exp_status[`AOS_ST_DONE]  = done;
      exp_status[`AOS_ST_ERR]   = err;
      exp_status[`AOS_ST_FIXED] = fixed;
    end
  endfunction
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      v = hrdata;
    end
  endtask
  task search(input [7:0] c);
    begin
      dly <= $urandom % 20 + 1;
      place <= 1'b1;
      bus(1'b1, `AOS_OFF_IRQ_STAT, 32'h0000_0007);
      place <= 1'b0;
      bus(1'b1, `AOS_OFF_CTRL, {24'h00_0000, c | 8'h01});
      bus(1'b0, `AOS_OFF_STATUS, 32'h0000_0000);
      while (v[`AOS_ST_BUSY]) bus(1'b0, `AOS_OFF_STATUS, 32'h0000_0000);
      st = v;
      @(posedge hclk);
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    de_q <= drive_en;
    if (drive_en) last_feed <= feed_rate;
    if (drive_en && !de_q) rise_feed <= feed_rate;
    if (drive_en && !de_q) n_move <= n_move + 1;
    if (counter_pulse) n_rev <= n_rev + 1;
    if (ptp_start) n_ptp <= n_ptp + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  end
  initial begin
    {hresetn, hsel, hwrite, place, nc, de_q} = 6'b000100;
    {haddr, htrans, dly, hwdata} = 0;
    {mismatches, n_compared, cycles, n_rev, n_ptp, n_move} = 0;
    v = $urandom(7806);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `AOS_OFF_CTRL, 0);
    chk(v, 32'h0000_0040);
    bus(1'b0, `AOS_OFF_STATUS, 0);
    chk(v, exp_status(1'b1, 1'b0, 1'b1));
    bus(1'b0, 8'h1C, 0);
    chk(v, 32'h0000_0000);
    hi = ($urandom & 32'h0000_FFFF) | 32'h0000_0001;
    lo = ($urandom & 32'h0000_FFFF) | 32'h0000_0001;
    off = $urandom | 32'h0000_0001;
    v = $urandom;
    nc <= v[0];
    bus(1'b1, `AOS_OFF_HIFEED, hi);
    bus(1'b1, `AOS_OFF_LOFEED, lo);
    bus(1'b1, `AOS_OFF_OFFSET, off);
    bus(1'b1, `AOS_OFF_IRQ_MASK, 32'h0000_0003);
    bus(1'b0, `AOS_OFF_HIFEED, 0);
    chk(v, hi);
    search({2'b01, nc, 5'b00010});
    chk(st, exp_status(1'b1, 1'b0, 1'b1));
    chk(n_rev, 1);
    chk(ptp_offset, off);
    chk({16'h0000, rise_feed}, hi);
    chk({16'h0000, last_feed}, lo);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b0, `AOS_OFF_IRQ_STAT, 0);
    chk(v, 32'h0000_0005);
    k = n_rev;
    search({2'b01, nc, 5'b00100});
    chk(st[1:0], 2'b10);
    chk(n_rev, k);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, `AOS_OFF_IRQ_MASK, 0);
    k = n_ptp;
    search({2'b11, nc, 5'b00010});
    chk(st, exp_status(1'b1, 1'b0, 1'b1));
    chk(n_ptp, k);
    chk({31'h0, irq}, 32'h0000_0000);
    search(8'b0001_0010);
    chk(st, exp_status(1'b1, 1'b0, 1'b1));
    chk(n_ptp, k + 1);
    chk({31'h0, decel_sel}, 32'h0000_0001);
    k = n_move;
    search(8'b0100_0000);
    chk(st[0], 1'b1);
    chk(n_move, k);
    search(8'b0100_0110);
    chk(st[1], 1'b1);
    end_of_test;
  end
endmodule // tb_axis_origin_search
